/* File: lasc_cfg.svh */
// holds the address map, bit positions, reset values and counts of the
// line alarm status and transmit control block
// assumes it is included by bare name in every file that needs a constant
`ifndef LASC_CFG_SVH
`define LASC_CFG_SVH

// channel count and port widths
`define LASC_NUM_CH 12
`define LASC_ADDR_W 8
`define LASC_DATA_W 8
`define LASC_IDX_W 4

// address layout: upper nibble picks the channel block, lower the register
`define LASC_BLK_HI 7
`define LASC_BLK_LO 4
`define LASC_OFF_HI 3
`define LASC_OFF_LO 0
`define LASC_OFF_STATUS 4'h3
`define LASC_OFF_TXCTL 4'h4
`define LASC_BLK_LOW_LAST 4'h5
`define LASC_BLK_HIGH_FIRST 4'h8
`define LASC_BLK_HIGH_LAST 4'hd
`define LASC_BLK_GAP 4'h2

// alarm status bits
`define LASC_ST_DMO_BIT 0
`define LASC_ST_LOS_BIT 1

// transmit control bits
`define LASC_TC_LEVEL_BIT 0
`define LASC_TC_EDGE_BIT 1
`define LASC_TC_AOS_BIT 2
`define LASC_TC_ERR_BIT 4
`define LASC_TC_MONSRC_BIT 5
`define LASC_TC_WR_MASK 8'h37
`define LASC_TC_RESET 8'h00
`define LASC_RD_IDLE 8'h00

// drive monitor: bit periods without a bipolar pulse before the alarm
`define LASC_DMON_CNT_W 8
`define LASC_DMON_LIMIT 8'h80
`define LASC_DMON_CNT_RESET 8'h00
`define LASC_DMON_CNT_STEP 8'h01

// synchroniser width: line clock, pad pos/neg, monitor pos/neg,
// three loss detectors, e3 mode
`define LASC_SYNC_W 9
`define LASC_SYNC_RESET 9'h000

`endif

/* File: lasc_pkg.sv */
// holds the shared types of the line alarm status block
// assumes lasc_cfg.svh is on the include path
`include "lasc_cfg.svh"

package lasc_pkg;
    typedef logic [`LASC_DATA_W-1:0] lasc_byte_type;
    typedef logic [`LASC_IDX_W-1:0] lasc_idx_type;
    typedef logic [`LASC_DMON_CNT_W-1:0] lasc_cnt_type;
endpackage : lasc_pkg

/* File: lasc_chan_alarm.sv */
// holds the per-channel alarm logic: loss of signal and drive monitor
// assumes all line-side inputs are asynchronous to clk_i and the line
// clock runs below half the rate of clk_i
`timescale 1ns/10ps
`default_nettype none
`include "lasc_cfg.svh"

module lasc_chan_alarm (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // line side, asynchronous
    input wire logic line_clk_i,
    input wire logic tx_line_out_pos_i,
    input wire logic tx_line_out_neg_i,
    input wire logic monitor_in_pos_i,
    input wire logic monitor_in_neg_i,
    input wire logic los_digital_i,
    input wire logic los_analog_i,
    input wire logic los_g775_i,
    input wire logic e3_mode_i,
    // configuration, same clock
    input wire logic mon_internal_i,
    // status
    output logic drive_monitor_alarm_o,
    output logic signal_loss_defect_o
);
    logic [`LASC_SYNC_W-1:0] meta_q;
    logic [`LASC_SYNC_W-1:0] sync_q;
    logic line_clk_prev_q;
    lasc_pkg::lasc_cnt_type idle_cnt_q;
    lasc_pkg::lasc_cnt_type idle_cnt_d;
    logic dmo_q;
    logic dmo_d;
    logic los_q;

    // named views of the synchronised inputs
    wire line_clk_s = sync_q[0];
    wire pad_pos_s = sync_q[1];
    wire pad_neg_s = sync_q[2];
    wire mon_pos_s = sync_q[3];
    wire mon_neg_s = sync_q[4];
    wire los_dig_s = sync_q[5];
    wire los_ana_s = sync_q[6];
    wire los_g775_s = sync_q[7];
    wire e3_s = sync_q[8];

    // bit period enable and pulse seen in that period
    wire bit_tick = line_clk_s & ~line_clk_prev_q;
    wire sel_pos = mon_internal_i ? pad_pos_s : mon_pos_s; // R03 R09
    wire sel_neg = mon_internal_i ? pad_neg_s : mon_neg_s; // R03 R09
    wire pulse_seen = sel_pos | sel_neg;
    wire los_any = e3_s ? los_g775_s : (los_dig_s | los_ana_s); // R01
    wire cnt_next_full =
        (idle_cnt_q + `LASC_DMON_CNT_STEP) == `LASC_DMON_LIMIT;

    // two-stage synchroniser for every line-side input
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= `LASC_SYNC_RESET;
            sync_q <= `LASC_SYNC_RESET;
        end else begin
            meta_q <= {e3_mode_i, los_g775_i, los_analog_i, los_digital_i,
                       monitor_in_neg_i, monitor_in_pos_i,
                       tx_line_out_neg_i, tx_line_out_pos_i, line_clk_i};
            sync_q <= meta_q;
        end
    end

    // idle bit-period count and alarm next state
    always_comb begin
        idle_cnt_d = idle_cnt_q;
        dmo_d = dmo_q;
        if (bit_tick) begin
            if (pulse_seen) begin
                idle_cnt_d = `LASC_DMON_CNT_RESET; // R10
                dmo_d = 1'b0; // R05
            end else if (!dmo_q) begin
                idle_cnt_d = idle_cnt_q + `LASC_DMON_CNT_STEP;
                dmo_d = cnt_next_full; // R04
            end
        end
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            line_clk_prev_q <= 1'b0;
            idle_cnt_q <= `LASC_DMON_CNT_RESET;
            dmo_q <= 1'b0; // R10
            los_q <= 1'b0; // R10
        end else begin
            line_clk_prev_q <= line_clk_s;
            idle_cnt_q <= idle_cnt_d;
            dmo_q <= dmo_d;
            los_q <= los_any; // R01
        end
    end

    assign drive_monitor_alarm_o = dmo_q;
    assign signal_loss_defect_o = los_q;
endmodule : lasc_chan_alarm

`default_nettype wire

/* File: lasc_top.sv */
// holds the twelve-channel alarm status and transmit control block with
// its parallel microprocessor register port
// assumes port strobes are synchronous to clk_i; line pins are not
//
// Contract
// R01 - loss is the digital or analog detector in DS3/STS-1, G.775 in E3.
// R02 - status bit 1 is read-only and shows the current loss of signal.
// R03 - the drive monitor seeks bipolar pulses at pads or monitor inputs.
// R04 - the drive-monitor alarm rises after 128 bit periods without a pulse.
// R05 - the drive-monitor alarm clears as soon as a bipolar pulse is seen.
// R06 - status bit 0 is read-only and shows the current drive-monitor alarm.
// R07 - tx control 7:0: rsvd, rsvd, source, error, rsvd, ones, edge, level.
// R08 - each of twelve channels has status at offset 3 of block 0-5 or 8-d.
// R09 - control bit 5 at 0 picks the monitor inputs, at 1 the pads.
// R10 - each pulse restarts the idle count; both status bits clear at reset.
`timescale 1ns/10ps
`default_nettype none
`include "lasc_cfg.svh"

module lasc_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // microprocessor port
    input wire logic [`LASC_ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [`LASC_DATA_W-1:0] wdata_i,
    output logic [`LASC_DATA_W-1:0] rdata_o,
    // per-channel line side
    input wire logic [`LASC_NUM_CH-1:0] line_clk_i,
    input wire logic [`LASC_NUM_CH-1:0] tx_line_out_pos_i,
    input wire logic [`LASC_NUM_CH-1:0] tx_line_out_neg_i,
    input wire logic [`LASC_NUM_CH-1:0] monitor_in_pos_i,
    input wire logic [`LASC_NUM_CH-1:0] monitor_in_neg_i,
    input wire logic [`LASC_NUM_CH-1:0] los_digital_i,
    input wire logic [`LASC_NUM_CH-1:0] los_analog_i,
    input wire logic [`LASC_NUM_CH-1:0] los_g775_i,
    input wire logic [`LASC_NUM_CH-1:0] e3_mode_i,
    // per-channel transmit controls
    output logic [`LASC_NUM_CH-1:0] tx_all_ones_force_o,
    output logic [`LASC_NUM_CH-1:0] tx_sample_edge_select_o,
    output logic [`LASC_NUM_CH-1:0] tx_output_level_select_o,
    output logic [`LASC_NUM_CH-1:0] prbs_error_insert_o,
    // per-channel alarms
    output logic [`LASC_NUM_CH-1:0] drive_monitor_alarm_o,
    output logic [`LASC_NUM_CH-1:0] signal_loss_defect_o
);
    lasc_pkg::lasc_byte_type tc_q [`LASC_NUM_CH];
    logic [`LASC_NUM_CH-1:0] err_pulse_q;
    logic [`LASC_NUM_CH-1:0] dmo_w;
    logic [`LASC_NUM_CH-1:0] los_w;
    lasc_pkg::lasc_byte_type rdata_q;
    lasc_pkg::lasc_byte_type rdata_d;

    // address decode: block nibble to channel index
    wire [`LASC_IDX_W-1:0] blk = addr_i[`LASC_BLK_HI:`LASC_BLK_LO];
    wire [`LASC_IDX_W-1:0] off = addr_i[`LASC_OFF_HI:`LASC_OFF_LO];
    wire blk_low = blk <= `LASC_BLK_LOW_LAST;
    wire blk_high = (blk >= `LASC_BLK_HIGH_FIRST) &&
                    (blk <= `LASC_BLK_HIGH_LAST);
    wire blk_ok = blk_low | blk_high; // R08
    wire [`LASC_IDX_W-1:0] ch_idx = blk_low ? blk : blk - `LASC_BLK_GAP;
    wire hit_status = blk_ok && (off == `LASC_OFF_STATUS); // R08
    wire hit_txctl = blk_ok && (off == `LASC_OFF_TXCTL);

    // read data selection; unmapped reads return zero
    wire [`LASC_DATA_W-1:0] status_rd = {
        {(`LASC_DATA_W-2){1'b0}},
        los_w[ch_idx], // R02
        dmo_w[ch_idx] // R06
    };
    wire [`LASC_DATA_W-1:0] txctl_rd = tc_q[ch_idx];

    always_comb begin
        rdata_d = rdata_q;
        if (rd_i) begin
            if (hit_status) begin
                rdata_d = status_rd;
            end else if (hit_txctl) begin
                rdata_d = txctl_rd;
            end else begin
                rdata_d = `LASC_RD_IDLE;
            end
        end
    end

    // read data register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_q <= `LASC_RD_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // one channel slice per channel
    genvar ch;
    generate
        for (ch = 0; ch < `LASC_NUM_CH; ch = ch + 1) begin : g_ch
            wire wr_sel = wr_i && hit_txctl &&
                          (ch_idx == lasc_pkg::lasc_idx_type'(ch));
            wire err_rise = wr_sel && wdata_i[`LASC_TC_ERR_BIT] &&
                            !tc_q[ch][`LASC_TC_ERR_BIT];

            // transmit control register; reserved bits stay zero
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    tc_q[ch] <= `LASC_TC_RESET;
                    err_pulse_q[ch] <= 1'b0;
                end else begin
                    if (wr_sel) begin
                        tc_q[ch] <= wdata_i & `LASC_TC_WR_MASK; // R07
                    end
                    err_pulse_q[ch] <= err_rise; // 0 to 1 inserts one error
                end
            end

            assign tx_all_ones_force_o[ch] = tc_q[ch][`LASC_TC_AOS_BIT];
            assign tx_sample_edge_select_o[ch] =
                tc_q[ch][`LASC_TC_EDGE_BIT];
            assign tx_output_level_select_o[ch] =
                tc_q[ch][`LASC_TC_LEVEL_BIT];
            assign prbs_error_insert_o[ch] = err_pulse_q[ch];

            lasc_chan_alarm u_alarm (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .line_clk_i(line_clk_i[ch]),
                .tx_line_out_pos_i(tx_line_out_pos_i[ch]),
                .tx_line_out_neg_i(tx_line_out_neg_i[ch]),
                .monitor_in_pos_i(monitor_in_pos_i[ch]),
                .monitor_in_neg_i(monitor_in_neg_i[ch]),
                .los_digital_i(los_digital_i[ch]),
                .los_analog_i(los_analog_i[ch]),
                .los_g775_i(los_g775_i[ch]),
                .e3_mode_i(e3_mode_i[ch]),
                .mon_internal_i(tc_q[ch][`LASC_TC_MONSRC_BIT]), // R09
                .drive_monitor_alarm_o(dmo_w[ch]),
                .signal_loss_defect_o(los_w[ch])
            );
        end
    endgenerate

    assign drive_monitor_alarm_o = dmo_w;
    assign signal_loss_defect_o = los_w;
endmodule : lasc_top

`default_nettype wire

/* File: lasc_line_model.sv */
// line side model: line clock plus bipolar marks at pads and monitor
// assumes clk_i is the system clock; half a bit period is 3 cycles
`timescale 1ns/10ps
`default_nettype none
module lasc_line_model (
    // system clock
    input wire logic clk_i,
    // mark enables
    input wire logic pad_on_i,
    input wire logic mon_on_i,
    // line side
    output logic line_clk_o,
    output logic pad_pos_o,
    output logic pad_neg_o,
    output logic mon_pos_o,
    output logic mon_neg_o
);
    logic [1:0] div_q = 2'h0;
    logic pol_q = 1'b0;
    initial {line_clk_o, pad_pos_o, pad_neg_o, mon_pos_o, mon_neg_o} = 5'h00;
    // new bit on each falling line edge, marks alternate polarity
    always @(negedge clk_i) begin
        div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        if (div_q == 2'h2) begin
            line_clk_o <= !line_clk_o;
            if (line_clk_o) begin
                pol_q <= !pol_q;
                pad_pos_o <= pad_on_i && pol_q;
                pad_neg_o <= pad_on_i && !pol_q;
                mon_pos_o <= mon_on_i && pol_q;
                mon_neg_o <= mon_on_i && !pol_q;
            end
        end
    end
endmodule : lasc_line_model
`default_nettype wire

/* File: lasc_top_assertions.sv */
// checker of the register port and channel alarms
// assumes it is bound to lasc_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module lasc_top_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    // channel side
    input wire logic [11:0] los_digital_i,
    input wire logic [11:0] los_analog_i,
    input wire logic [11:0] los_g775_i,
    input wire logic [11:0] e3_mode_i,
    input wire logic [11:0] tx_all_ones_force_o,
    input wire logic [11:0] prbs_error_insert_o,
    input wire logic [11:0] drive_monitor_alarm_o,
    input wire logic [11:0] signal_loss_defect_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [1:0] age_q;
    // mapped status or control address
    wire logic [3:0] blk = addr_i[7:4];
    wire logic hit = (blk < 4'h6 || (blk > 4'h7 && blk < 4'he))
        && (addr_i[3:0] == 4'h3 || addr_i[3:0] == 4'h4);
    // cycles since reset, saturating
    always_ff @(posedge clk_i) begin
        if (srst_i) age_q <= 2'h0;
        else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end
    property p_rst;
        disable iff (1'b0) srst_i |=> rdata_o == 8'h00
            && drive_monitor_alarm_o == 12'h000
            && signal_loss_defect_o == 12'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_idle;
        rd_i && !hit |=> rdata_o == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("unmapped read");
    property p_st0;
        rd_i && addr_i == 8'h03 |=> rdata_o == {6'h00,
            $past(signal_loss_defect_o[0]), $past(drive_monitor_alarm_o[0])};
    endproperty
    a_st0: assert property (p_st0) else $error("status ch0");
    property p_st6;
        rd_i && addr_i == 8'h83 |=> rdata_o[1:0] == {
            $past(signal_loss_defect_o[6]), $past(drive_monitor_alarm_o[6])};
    endproperty
    a_st6: assert property (p_st6) else $error("status ch6");
    property p_tcw;
        wr_i && addr_i == 8'h04 |=>
            tx_all_ones_force_o[0] == $past(wdata_i[2]);
    endproperty
    a_tcw: assert property (p_tcw) else $error("control write");
    property p_err;
        $rose(prbs_error_insert_o[0]) |-> $past(wr_i)
            && $past(addr_i) == 8'h04 && $past(wdata_i[4]);
    endproperty
    a_err: assert property (p_err) else $error("error pulse cause");
    property p_err1;
        prbs_error_insert_o[0] |=> !prbs_error_insert_o[0];
    endproperty
    a_err1: assert property (p_err1) else $error("error pulse long");
    property p_los;
        age_q == 2'h3 |-> signal_loss_defect_o[0] == ($past(e3_mode_i[0], 3)
            ? $past(los_g775_i[0], 3)
            : ($past(los_digital_i[0], 3) || $past(los_analog_i[0], 3)));
    endproperty
    a_los: assert property (p_los) else $error("loss merge");
    c_los: cover property (signal_loss_defect_o[0]);
    c_dmo: cover property ($fell(drive_monitor_alarm_o[0]));
    c_err: cover property (prbs_error_insert_o[0]);
endmodule : lasc_top_assertions
bind lasc_top lasc_top_assertions u_lasc_top_assertions (.*);
`default_nettype wire

/* File: line_alarm_status_tx_control_test.sv */
// testbench: registers, loss merge and drive monitor of channel 0
// assumes lasc_line_model feeds every channel's line side
`timescale 1ns/10ps
`default_nettype none
module line_alarm_status_tx_control_test;
    logic clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v;
    logic [11:0] ld = 12'h0, la = 12'h0, lg = 12'h0, e3 = 12'h0;
    logic [11:0] aos, edg, lev, err, drive_monitor_alarm, signal_loss_defect;
    logic pad_on = 1'b1, mon_on = 1'b1;
    wire logic lclk, pp, pn, mp, mn;
    int miscompares = 0, checks = 0;
    lasc_line_model u_lasc_line_model (.clk_i(clk_i), .pad_on_i(pad_on),
        .mon_on_i(mon_on), .line_clk_o(lclk), .pad_pos_o(pp),
        .pad_neg_o(pn), .mon_pos_o(mp), .mon_neg_o(mn));
    lasc_top u_lasc_top (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .line_clk_i({12{lclk}}), .tx_line_out_pos_i({12{pp}}),
        .tx_line_out_neg_i({12{pn}}), .monitor_in_pos_i({12{mp}}),
        .monitor_in_neg_i({12{mn}}), .los_digital_i(ld),
        .los_analog_i(la), .los_g775_i(lg), .e3_mode_i(e3),
        .tx_all_ones_force_o(aos), .tx_sample_edge_select_o(edg),
        .tx_output_level_select_o(lev), .prbs_error_insert_o(err),
        .drive_monitor_alarm_o(drive_monitor_alarm), .signal_loss_defect_o(signal_loss_defect));
    initial forever #10 clk_i = ~clk_i;
    task chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge clk_i);
        wr_i = 1'b0;
        @(negedge clk_i);
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge clk_i);
        d = rdata_o;
        rd_i = 1'b0;
        @(negedge clk_i);
    endtask : rd
    task ticks(input int n);
        repeat (n) @(posedge lclk);
        repeat (5) @(negedge clk_i);
    endtask : ticks
    // line goes quiet right after a marked bit
    task quiet;
        ticks(127);
        chk(drive_monitor_alarm[0], 1'b0);
        ticks(1);
        chk(drive_monitor_alarm[0], 1'b1);
    endtask : quiet
    task t_regs;
        // first control write, watching the one-cycle error pulse
        addr_i = 8'h04;
        wdata_i = 8'hff;
        wr_i = 1'b1;
        @(negedge clk_i);
        wr_i = 1'b0;
        chk(err, 12'h001);
        @(negedge clk_i);
        chk(err, 12'h000);
        rd(8'h04, v);
        chk(v, 8'h37);
        rd(8'h63, v);
        chk(v, 8'h00);
        rd(8'h83, v);
        chk(v, 8'h00);
        for (int i = 0; i < 12; i++)
            wr({i < 6 ? i[3:0] : i[3:0] + 4'h2, 4'h4}, {4'hc, i[3:0]});
        for (int i = 0; i < 12; i++) begin
            rd({i < 6 ? i[3:0] : i[3:0] + 4'h2, 4'h4}, v);
            chk(v, {4'h0, i[3:0]} & 8'h37);
        end
        chk(lev, 12'haaa);
        chk(edg, 12'hccc);
        chk(aos, 12'h0f0);
    endtask : t_regs
    task t_los;
        for (int i = 0; i < 16; i++) begin
            {e3[0], ld[0], la[0], lg[0]} = i[3:0];
            repeat (5) @(negedge clk_i);
            rd(8'h03, v);
            chk(v[1], i[3] ? i[0] : i[2] | i[1]);
            chk(signal_loss_defect[0], i[3] ? i[0] : i[2] | i[1]);
        end
        {e3[0], ld[0], la[0], lg[0]} = 4'h0;
    endtask : t_los
    task t_dmo;
        @(posedge lclk);
        mon_on = 1'b0;
        quiet;
        @(posedge lclk);
        mon_on = 1'b1;
        ticks(0);
        chk(drive_monitor_alarm[0], 1'b1);
        ticks(1);
        chk(drive_monitor_alarm[0], 1'b0);
        @(posedge lclk);
        mon_on = 1'b0;
        wr(8'h04, 8'h20);
        ticks(130);
        chk(drive_monitor_alarm[0], 1'b0);
        @(posedge lclk);
        pad_on = 1'b0;
        quiet;
        rd(8'h03, v);
        chk(v, 8'h01);
    endtask : t_dmo
    task final_report;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(negedge clk_i);
        srst_i = 1'b0;
        rd(8'h03, v);
        chk(v, 8'h00);
        t_regs;
        t_los;
        t_dmo;
        final_report;
    end
    // watchdog
    initial begin
        #200000;
        miscompares++;
        final_report;
    end
endmodule : line_alarm_status_tx_control_test
`default_nettype wire
